// [pkg/lpci_params.svh]
// Offsets, field positions, buffer and page geometry and character codes of the printer interpreter
`ifndef LPCI_PARAMS_SVH
`define LPCI_PARAMS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define LPCI_REG_CHAR 8'h00
`define LPCI_REG_CMD 8'h04
`define LPCI_REG_STATUS 8'h08
`define LPCI_REG_FMT 8'h0C
`define LPCI_REG_ADDR 8'h10
`define LPCI_REG_COUNT 8'h14
`define LPCI_REG_CFG 8'h18
`define LPCI_REG_LEVEL 8'h1C
// ****************************************
// Command fields
// ****************************************
`define LPCI_CMD_START 8
`define LPCI_CMD_CLEAR 9
`define LPCI_CMD_DMA 10
`define LPCI_DEV_ONE 6'h0F
`define LPCI_DEV_TWO 6'h2F
`define LPCI_PRIO_BIT 4'hC
// ****************************************
// Buffer and page geometry
// ****************************************
`define LPCI_BUF_DEPTH 3000
`define LPCI_BUF_HALF 12'h5DC
`define LPCI_BUF_LAST 12'hBB7
`define LPCI_LINE_MAX 8'h84
`define LPCI_FORM_LINES 8'h42
// ****************************************
// Character codes
// ****************************************
`define LPCI_C_BS 7'h08
`define LPCI_C_HT 7'h09
`define LPCI_C_NL 7'h0A
`define LPCI_C_VT 7'h0B
`define LPCI_C_FF 7'h0C
`define LPCI_C_CR 7'h0D
`define LPCI_C_SO 7'h0E
`define LPCI_C_SI 7'h0F
`define LPCI_C_ESC 7'h1B
`define LPCI_C_SPACE 7'h20
`define LPCI_C_TILDE 7'h7E
`define LPCI_E_HSET 7'h31
`define LPCI_E_HCLR 7'h32
`define LPCI_E_VSET 7'h35
`define LPCI_E_VCLR 7'h36
`endif

// [pkg/lpci_pkg.sv]
// Types and shared functions of the printer interpreter
package lpci_pkg;
`include "lpci_params.svh"
   typedef enum logic [1:0] {IP_IDLE, IP_DECODE, IP_EMIT} lpci_ip_t;
   typedef enum logic [2:0] {OP_PRINT, OP_BACK, OP_HTAB, OP_NEWLINE, OP_VTAB, OP_FORM,
      OP_RETURN, OP_CSET} lpci_op_t;

   // Line terminator test, used by buffer and interpreter
   function automatic logic lpci_is_term(input logic [6:0] c);
      return (c >= `LPCI_C_NL) && (c <= `LPCI_C_CR);
   endfunction
endpackage

// [core/lpci_char_buf.sv]
// Character buffer with fill/half-drain hysteresis and terminator count
`timescale 1ns/10ps
module lpci_char_buf
   import lpci_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic push,
   input wire logic [6:0] push_data,
   input wire logic pop,
   output logic [6:0] head,
   output logic empty,
   output logic in_ready,
   output logic term_pend,
   output logic [11:0] level
);
   typedef struct packed {
      logic [`LPCI_BUF_DEPTH-1:0][6:0] mem;
      logic [11:0] wr_ptr;
      logic [11:0] rd_ptr;
      logic [11:0] count;
      logic stall;
      logic [11:0] terms;
   } lpci_buf_t;

   lpci_buf_t q, d;
   logic do_push, do_pop;

   // Pushes beyond in_ready are the caller's fault; they are dropped here
   assign do_push = push & in_ready;
   assign do_pop = pop & ~empty;
   assign head = q.mem[q.rd_ptr];
   assign empty = (q.count == 12'h000);
   assign in_ready = ~q.stall;
   assign term_pend = (q.terms != 12'h000);
   assign level = q.count;

   // Arrival-order ring of flip-flops
   always_comb begin
      d = q;
      if (do_push) begin
         d.mem[q.wr_ptr] = push_data;
         d.wr_ptr = (q.wr_ptr == `LPCI_BUF_LAST) ? 12'h000 : q.wr_ptr + 12'h001;
      end
      if (do_pop) begin
         d.rd_ptr = (q.rd_ptr == `LPCI_BUF_LAST) ? 12'h000 : q.rd_ptr + 12'h001;
      end
      d.count = q.count + {11'h000, do_push} - {11'h000, do_pop};
      d.terms = q.terms + {11'h000, do_push & lpci_is_term(push_data)}
         - {11'h000, do_pop & lpci_is_term(head)};
      if (d.count == `LPCI_BUF_LAST + 12'h001) begin
         d.stall = 1'b1;
      end else if (d.count <= `LPCI_BUF_HALF) begin
         d.stall = 1'b0;
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// [core/lpci_top.sv]
// Line printer controller and code interpreter behind an AXI4-Lite slave
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module lpci_top
   import lpci_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [15:0] dch_addr,
   output logic dch_ready,
   input wire logic dch_valid,
   input wire logic [6:0] dch_byte,
   input wire logic online_pin,
   input wire logic esc_disable_pin,
   input wire logic ff_option_pin,
   output logic buf_room,
   output logic prn_valid,
   input wire logic prn_ready,
   output logic [2:0] prn_op,
   output logic [6:0] prn_char,
   output logic [7:0] prn_pos,
   output logic prn_alt,
   output logic prn_route
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic aw_ok;
      logic [7:0] aw_addr;
      logic w_ok;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic pio_busy;
      logic pio_done;
      logic [6:0] pio_char;
      logic unit_two;
      logic fmt_inh;
      logic dma_busy;
      logic dma_done;
      logic [15:0] dma_addr;
      logic [15:0] dma_cnt;
      logic [1:0] online_sy;
      logic [1:0] escd_sy;
      logic [1:0] ffo_sy;
      lpci_ip_t ip;
      logic [6:0] code;
      logic esc_pend;
      logic alt_set;
      logic [7:0] col;
      logic [7:0] line;
      logic [7:0] char_cnt;
      logic [131:0] htab;
      logic [131:0] vtab;
      lpci_op_t op;
      logic [6:0] op_char;
      logic [7:0] op_pos;
      logic route;
   } lpci_state_t;

   lpci_state_t q, d;
   logic wr_fire, cmd_hit, code_ok, pio_start, pio_clear, dma_start, dma_clear;
   logic pio_push, dma_push, buf_push, buf_pop, buf_empty, buf_in_ready, term_pend;
   logic [6:0] buf_head, push_data;
   logic [11:0] buf_level;
   logic [31:0] wval, addr_mrg, cnt_mrg;

   // Byte-lane merge of a write into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Nearest set stop above from and below lim, {found, index}
   function automatic logic [8:0] next_stop(input logic [131:0] s, input logic [7:0] from,
                                            input logic [7:0] lim);
      logic [8:0] r;
      r = 9'h000;
      for (int i = 131; i >= 0; i--) begin
         if (s[i] && (8'(i) > from) && (8'(i) < lim)) begin
            r = {1'b1, 8'(i)};
         end
      end
      return r;
   endfunction

   // ****************************************
   // Command decode
   // ****************************************
   assign wr_fire = q.aw_ok & q.w_ok & ~q.bvalid;
   assign wval = merge(32'h0000_0000, q.w_data, q.w_strb);
   assign addr_mrg = merge({16'h0000, q.dma_addr}, q.w_data, q.w_strb);
   assign cnt_mrg = merge({16'h0000, q.dma_cnt}, q.w_data, q.w_strb);
   assign cmd_hit = wr_fire & (q.aw_addr == `LPCI_REG_CMD);
   // one unit code at a time, chosen by configuration
   assign code_ok = wval[5:0] == (q.unit_two ? `LPCI_DEV_TWO : `LPCI_DEV_ONE);
   assign pio_start = cmd_hit & code_ok & wval[`LPCI_CMD_START] & ~wval[`LPCI_CMD_DMA];
   assign pio_clear = cmd_hit & code_ok & wval[`LPCI_CMD_CLEAR] & ~wval[`LPCI_CMD_DMA];
   assign dma_start = cmd_hit & code_ok & wval[`LPCI_CMD_START] & wval[`LPCI_CMD_DMA];
   assign dma_clear = cmd_hit & code_ok & wval[`LPCI_CMD_CLEAR] & wval[`LPCI_CMD_DMA];

   // Intake: programmed unit first, block unit only when it is idle
   assign pio_push = q.pio_busy & buf_in_ready;
   assign dch_ready = q.dma_busy & ~q.pio_busy & buf_in_ready & (q.dma_cnt != 16'h0000);
   assign dma_push = dch_ready & dch_valid;
   assign buf_push = pio_push | dma_push;
   assign push_data = pio_push ? q.pio_char : dch_byte;
   assign buf_pop = (q.ip == IP_IDLE) & ~buf_empty;

   // room handshake seen by the host
   assign buf_room = buf_in_ready;
   assign dch_addr = q.dma_addr;

   lpci_char_buf u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .push(buf_push),
      .push_data(push_data),
      .pop(buf_pop),
      .head(buf_head),
      .empty(buf_empty),
      .in_ready(buf_in_ready),
      .term_pend(term_pend),
      .level(buf_level)
   );

   assign s_axi_awready = ~q.aw_ok;
   assign s_axi_wready = ~q.w_ok;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = ~q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign prn_valid = (q.ip == IP_EMIT);
   assign prn_op = q.op;
   assign prn_char = q.op_char;
   assign prn_pos = q.op_pos;
   assign prn_alt = q.alt_set;
   assign prn_route = q.route;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic normal;
      logic [8:0] stop;
      logic [6:0] c;
      normal = 1'b0;
      stop = 9'h000;
      c = q.code;
      d = q;
      // Pin synchronisers, only the second stage is read
      d.online_sy = {q.online_sy[0], online_pin};
      d.escd_sy = {q.escd_sy[0], esc_disable_pin};
      d.ffo_sy = {q.ffo_sy[0], ff_option_pin};
      // Write channel, address and data in either order
      if (s_axi_awvalid && !q.aw_ok) begin
         d.aw_ok = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_ok) begin
         d.w_ok = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         d.aw_ok = 1'b0;
         d.w_ok = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = 2'h0;
         case (q.aw_addr)
            `LPCI_REG_CHAR: d.pio_char = wval[6:0];
            `LPCI_REG_CMD: ;
            `LPCI_REG_ADDR: d.dma_addr = addr_mrg[15:0];
            `LPCI_REG_COUNT: d.dma_cnt = cnt_mrg[15:0];
            `LPCI_REG_FMT: d.fmt_inh = wval[0];
            `LPCI_REG_CFG: d.unit_two = wval[0];
            `LPCI_REG_STATUS, `LPCI_REG_LEVEL: ;
            default: d.bresp = 2'h2;
         endcase
      end
      // Read channel; status read has no side effect
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp = 2'h0;
         d.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            `LPCI_REG_CHAR: d.rdata[6:0] = q.pio_char;
            `LPCI_REG_CMD: ;
            `LPCI_REG_STATUS: d.rdata = {12'h000, `LPCI_PRIO_BIT, 8'h00, q.alt_set,
               q.online_sy[1], buf_in_ready, q.fmt_inh, q.dma_done, q.dma_busy,
               q.pio_done, q.pio_busy};
            `LPCI_REG_FMT: d.rdata[0] = q.fmt_inh;
            `LPCI_REG_ADDR: d.rdata[15:0] = q.dma_addr;
            `LPCI_REG_COUNT: d.rdata[15:0] = q.dma_cnt;
            `LPCI_REG_CFG: d.rdata[0] = q.unit_two;
            `LPCI_REG_LEVEL: d.rdata[11:0] = buf_level;
            default: d.rresp = 2'h2;
         endcase
      end
      if (pio_clear) begin
         d.pio_busy = 1'b0;
         d.pio_done = 1'b0;
      end
      // start hands the held character to the buffer
      if (pio_start) begin
         d.pio_busy = 1'b1;
         d.pio_done = 1'b0;
      end
      // Completion wins over a clear in the same cycle
      if (pio_push) begin
         d.pio_busy = 1'b0;
         d.pio_done = 1'b1;
      end
      // clear halts the transfer and drops busy, done and the format inhibit
      if (dma_clear) begin
         d.dma_busy = 1'b0;
         d.dma_done = 1'b0;
         d.fmt_inh = 1'b0;
      end
      if (dma_start) begin
         d.dma_busy = 1'b1;
         d.dma_done = 1'b0;
      end
      // counters step with each byte taken
      if (dma_push) begin
         d.dma_addr = q.dma_addr + 16'h0001;
         d.dma_cnt = q.dma_cnt - 16'h0001;
      end
      // Completion wins over a clear, as on the programmed unit
      if (q.dma_busy && !dma_start && q.dma_cnt == 16'h0000) begin
         d.dma_busy = 1'b0;
         d.dma_done = 1'b1;
      end
      // ****************************************
      // Interpreter
      // ****************************************
      case (q.ip)
         IP_IDLE: begin
            if (buf_pop) begin
               d.code = buf_head;
               d.ip = IP_DECODE;
            end
         end
         IP_DECODE: begin
            d.ip = IP_IDLE;
            d.op_char = c;
            if (q.esc_pend) begin
               d.esc_pend = 1'b0;
               // tab functions are the only valid followers
               if (c == `LPCI_E_HSET && q.col != 8'h00) begin
                  d.htab[q.col] = 1'b1;
               end else if (c == `LPCI_E_HCLR) begin
                  d.htab[q.col] = 1'b0;
               end else if (c == `LPCI_E_VSET) begin
                  d.vtab[q.line] = 1'b1;
               end else if (c == `LPCI_E_VCLR) begin
                  d.vtab[q.line] = 1'b0;
               end else begin
                  normal = 1'b1;
               end
            end else begin
               normal = 1'b1;
            end
            if (normal) begin
               // any terminator restarts the line count
               if (lpci_is_term(c)) begin
                  d.char_cnt = 8'h00;
               end
               if (c >= `LPCI_C_SPACE && c <= `LPCI_C_TILDE) begin
                  // print unless the line is full
                  if (q.char_cnt < `LPCI_LINE_MAX) begin
                     d.char_cnt = q.char_cnt + 8'h01;
                     d.op = OP_PRINT;
                     d.op_pos = q.col;
                     d.col = (q.col < `LPCI_LINE_MAX - 8'h01) ? q.col + 8'h01 : q.col;
                     d.ip = IP_EMIT;
                  end
               end else begin
                  case (c)
                     // escape opens a sequence unless disabled
                     `LPCI_C_ESC: d.esc_pend = ~q.escd_sy[1];
                     `LPCI_C_BS: begin
                        if (q.online_sy[1] && q.col != 8'h00) begin
                           d.col = q.col - 8'h01;
                           d.op = OP_BACK;
                           d.op_pos = d.col;
                           d.ip = IP_EMIT;
                        end
                     end
                     // tab to next stop, none set means no move
                     `LPCI_C_HT: begin
                        stop = next_stop(q.htab, q.col, `LPCI_LINE_MAX);
                        if (stop[8] && !q.fmt_inh) begin
                           d.col = stop[7:0];
                           d.op = OP_HTAB;
                           d.op_pos = stop[7:0];
                           d.ip = IP_EMIT;
                        end
                     end
                     // newline, route planned when a whole line waits
                     `LPCI_C_NL: begin
                        d.line = (q.line == `LPCI_FORM_LINES - 8'h01) ? 8'h00 : q.line + 8'h01;
                        d.col = 8'h00;
                        d.route = term_pend;
                        d.op = OP_NEWLINE;
                        d.op_pos = d.line;
                        d.ip = IP_EMIT;
                     end
                     // vertical tab within the current form
                     `LPCI_C_VT: begin
                        stop = next_stop(q.vtab, q.line, `LPCI_FORM_LINES);
                        if (stop[8] && q.ffo_sy[1] && !q.fmt_inh) begin
                           d.line = stop[7:0];
                           d.op = OP_VTAB;
                           d.op_pos = stop[7:0];
                           d.ip = IP_EMIT;
                        end
                     end
                     // form feed needs the form option
                     `LPCI_C_FF: begin
                        if (q.ffo_sy[1] && !q.fmt_inh) begin
                           d.line = 8'h00;
                           d.op = OP_FORM;
                           d.op_pos = 8'h00;
                           d.ip = IP_EMIT;
                        end
                     end
                     `LPCI_C_CR: begin
                        d.col = 8'h00;
                        d.op = OP_RETURN;
                        d.op_pos = 8'h00;
                        d.ip = IP_EMIT;
                     end
                     `LPCI_C_SO, `LPCI_C_SI: begin
                        d.alt_set = (c == `LPCI_C_SO);
                        d.op = OP_CSET;
                        d.op_pos = q.col;
                        d.ip = IP_EMIT;
                     end
                     default: ;
                  endcase
               end
            end
         end
         IP_EMIT: begin
            if (prn_ready) begin
               d.ip = IP_IDLE;
            end
         end
         default: d.ip = IP_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   start_pio_busy_a: assert property (pio_start && !q.pio_busy |=> q.pio_busy && !q.pio_done)
      else $error("start did not raise busy");
   clear_keeps_char_a: assert property (pio_clear && !pio_start && !pio_push
      |=> !q.pio_busy && !q.pio_done
      && q.pio_char == $past(q.pio_char))
      else $error("clear changed char or left flags");
   wrong_code_a: assert property (cmd_hit && !code_ok |=> q.pio_busy == $past(q.pio_busy)
      && q.dma_busy == $past(q.dma_busy))
      else $error("foreign device code acted on");
   dma_start_a: assert property (dma_start |=> q.dma_busy && !q.dma_done)
      else $error("block start not taken");
   dma_clear_a: assert property (dma_clear && !dma_start |=> !q.dma_busy && !dch_ready
      && !q.fmt_inh)
      else $error("block clear did not halt");
   addr_step_a: assert property (dma_push |=> q.dma_addr == $past(q.dma_addr) + 16'h0001)
      else $error("address counter did not step");
   line_limit_a: assert property (prn_valid && prn_op == OP_PRINT |-> prn_pos < `LPCI_LINE_MAX)
      else $error("print past column limit");
   full_stops_a: assert property (buf_level == `LPCI_BUF_LAST + 12'h001 |-> !buf_room)
      else $error("room shown while full");
   room_gate_a: assert property (dch_ready |-> buf_room)
      else $error("intake while no room");
   // Pins are judged in the decode cycle; they may move while the action waits
   back_online_a: assert property ($rose(prn_valid) && prn_op == OP_BACK
      |-> $past(q.online_sy[1]))
      else $error("backspace while offline");
   form_option_a: assert property ($rose(prn_valid) && prn_op == OP_FORM
      |-> $past(q.ffo_sy[1]))
      else $error("form feed without option");
   emit_hold_a: assert property (prn_valid && !prn_ready |=> prn_valid && $stable(prn_op))
      else $error("printer action dropped early");

   print_seen_c: cover property (prn_valid && prn_ready && prn_op == OP_PRINT);
   newline_seen_c: cover property (prn_valid && prn_op == OP_NEWLINE && prn_route);
   dma_done_c: cover property (q.dma_busy ##1 q.dma_done);
   buffer_full_c: cover property (!buf_room);
endmodule

// [bench/lpci_prn_model.sv]
// Printer mechanism model that takes actions, stalling every other cycle
`timescale 1ns/10ps
module lpci_prn_model
   import lpci_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic prn_valid,
   input wire logic [2:0] prn_op,
   input wire logic [6:0] prn_char,
   output logic prn_ready,
   output logic [2:0] last_op,
   output logic [6:0] last_char,
   output logic [7:0] n_act
);
   // Ready alternates so actions meet both a stall and a prompt take
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prn_ready <= 1'b0;
         n_act <= 8'h00;
      end else begin
         prn_ready <= ~prn_ready;
         if (prn_valid && prn_ready) begin
            n_act <= n_act + 8'h01;
            last_op <= prn_op;
            last_char <= prn_char;
         end
      end
   end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the printer interpreter
`timescale 1ns/10ps
module testbench
   import lpci_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic prn_ready, prn_valid, dch_valid, buf_room;
   logic [7:0] s_axi_awaddr, s_axi_araddr, n_act;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] prn_op, last_op;
   logic [6:0] prn_char, last_char;
   int failures, n_checks, cyc;
   lpci_top uut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .dch_addr(), .dch_ready(), .dch_valid, .dch_byte(7'h58),
      .online_pin(1'b1), .esc_disable_pin(1'b0), .ff_option_pin(1'b0), .buf_room, .prn_valid,
      .prn_ready, .prn_op, .prn_char, .prn_pos(), .prn_alt(), .prn_route());
   lpci_prn_model pm(.aclk, .aresetn, .prn_valid, .prn_op, .prn_char, .prn_ready, .last_op,
      .last_char, .n_act);
   // ****************************************
   // Shared tasks
   // ****************************************
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Handshakes judged before the edge, released just after it
   task axw(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task axr(input logic [7:0] a);
      logic ta, tb;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_arready;
         tb = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tb);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Hand one code to the programmed unit and wait for it to finish
   task go(input logic [6:0] c);
      axw(8'h00, {25'h0, c});
      axw(8'h04, 32'h0000_010F);
      do axr(8'h08); while (d[1] !== 1'b1);
   endtask
   task finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_print;
      go(7'h41);
      repeat (8) @(posedge aclk);
      chk("print count", n_act, 8'h01);
      chk("print op", last_op, OP_PRINT);
      chk("print char", last_char, 7'h41);
      axr(8'h08);
      chk("status done", d, 32'h000C_0062);
      axr(8'h08);
      chk("status again", d, 32'h000C_0062);
   endtask
   task t_ctrl;
      go(7'h07);
      go(7'h0D);
      repeat (8) @(posedge aclk);
      chk("bell dropped", n_act, 8'h02);
      chk("return op", last_op, OP_RETURN);
   endtask
   task t_clear;
      axw(8'h04, 32'h0000_020F);
      axr(8'h08);
      chk("status clear", d, 32'h000C_0060);
      axr(8'h00);
      chk("char kept", d, 32'h0000_000D);
      axw(8'h04, 32'h0000_012F);
      axr(8'h08);
      chk("foreign code", d, 32'h000C_0060);
   endtask
   task t_map;
      axw(8'h10, 32'h0000_1234);
      axr(8'h10);
      chk("addr counter", d, 32'h0000_1234);
      axr(8'h40);
      chk("unmapped resp", r, 2'h2);
   endtask
   // Two bytes through the block unit, memory side always offering
   task t_dma;
      axw(8'h14, 32'h0000_0002);
      axw(8'h04, 32'h0000_050F);
      dch_valid <= 1'b1;
      repeat (12) @(posedge aclk);
      dch_valid <= 1'b0;
      chk("room", buf_room, 1'b1);
      axr(8'h10);
      chk("dma addr", d, 32'h0000_1236);
      axr(8'h14);
      chk("dma count", d, 32'h0000_0000);
      axr(8'h08);
      chk("dma done", d, 32'h000C_0068);
      axw(8'h04, 32'h0000_060F);
      axr(8'h08);
      chk("dma clear", d, 32'h000C_0060);
      chk("dma prints", n_act, 8'h04);
      chk("dma char", last_char, 7'h58);
   endtask
   // Clock, reset and run order
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      {aresetn, dch_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      s_axi_rready = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axr(8'h08);
      chk("status reset", d, 32'h000C_0060);
      t_print;
      t_ctrl;
      t_clear;
      t_map;
      t_dma;
      finish_test;
   end
   // Hang guard, far above the roughly 135 cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         finish_test;
      end
   end
endmodule
